// ---- logic/tos_pkg.sv ----
// constants and types shared by the tile otp security block
package tos_pkg;
  // ==========================================================
  // protection word layout
  localparam int unsigned TOS_BIT_JTAG_OFF  = 0;
  localparam int unsigned TOS_BIT_LINK_OFF  = 1;
  localparam int unsigned TOS_BIT_SEC_BOOT  = 5;
  localparam int unsigned TOS_BIT_REDUND    = 7;
  localparam int unsigned TOS_BIT_LOCK_LO   = 8;
  localparam int unsigned TOS_BIT_MASTER    = 12;
  localparam int unsigned TOS_BIT_JOTP_OFF  = 13;
  localparam int unsigned TOS_GP_LO         = 15;
  localparam int unsigned TOS_GP_HI         = 21;
  localparam int unsigned TOS_UID_LO        = 22;
  localparam int unsigned TOS_UID_HI        = 31;
  localparam logic [31:0] TOS_SETTINGS_RST  = 32'h0000_0000;
  // ==========================================================
  // otp and sram geometry
  localparam int unsigned TOS_OTP_SECTORS   = 4;
  localparam int unsigned TOS_OTP_ROWS      = 512;
  localparam int unsigned TOS_OTP_WORDS     = TOS_OTP_SECTORS * TOS_OTP_ROWS;
  localparam int unsigned TOS_OTP_AW        = 11;
  localparam int unsigned TOS_ROW_AW        = 9;
  localparam int unsigned TOS_SRAM_WORDS    = 32768;
  localparam int unsigned TOS_SRAM_AW       = 15;
  localparam logic [10:0] TOS_OTP_LAST      = 11'h7FF;
  // ==========================================================
  // programming control port bit positions
  localparam int unsigned TOS_CTL_PROG      = 0;
  localparam int unsigned TOS_CTL_PROT      = 1;
  localparam int unsigned TOS_CTL_READ      = 2;
  // ==========================================================
  // test access port
  localparam int unsigned TOS_IR_LEN        = 4;
  localparam int unsigned TOS_DR_LEN        = 32;
  localparam logic [3:0]  TOS_IR_TEST_PORT_IDENTIFICATION     = 4'h1;
  localparam logic [3:0]  TOS_IR_CHIP       = 4'h2;
  localparam logic [3:0]  TOS_IR_OTP_RD     = 4'h3;
  localparam logic [3:0]  TOS_IR_USERCODE   = 4'h8;
  localparam logic [3:0]  TOS_IR_BYPASS     = 4'hF;
  localparam logic [3:0]  TOS_IR_CAPTURE    = 4'h1;
  localparam logic [5:0]  TOS_UC_UNUSED     = 6'h00;

  typedef enum logic [2:0] {
    TOS_BS_LOAD = 3'b001,
    TOS_BS_COPY = 3'b010,
    TOS_BS_RUN  = 3'b100
  } tos_boot_e;

  typedef enum logic [15:0] {
    TOS_TLR = 16'h0001, TOS_RTI = 16'h0002, TOS_SDS = 16'h0004, TOS_CDR = 16'h0008,
    TOS_SDR = 16'h0010, TOS_E1D = 16'h0020, TOS_PDR = 16'h0040, TOS_E2D = 16'h0080,
    TOS_UDR = 16'h0100, TOS_SIS = 16'h0200, TOS_CIR = 16'h0400, TOS_SIR = 16'h0800,
    TOS_E1I = 16'h1000, TOS_PIR = 16'h2000, TOS_E2I = 16'h4000, TOS_UIR = 16'h8000
  } tos_tap_e;
endpackage : tos_pkg

// ---- logic/tos_top.sv ----
// tile protection word, otp store, boot copy, sram bank and test access port
`timescale 1ns/1ps
module tos_top #(
  parameter logic [3:0]  ID_VERSION  = 4'h0,   // arbitrary value
  parameter logic [15:0] ID_PART     = 16'h1234, // arbitrary value
  parameter logic [10:0] ID_MAKER    = 11'h155, // arbitrary value
  parameter logic [15:0] SI_REVISION = 16'h0042  // arbitrary value
) (
  input  wire logic                          clk,
  input  wire logic                          rst_n,
  input  wire logic [15:0]                   otp_addr_port,
  input  wire logic [31:0]                   otp_data_port,
  input  wire logic [15:0]                   otp_ctrl_port,
  output logic      [31:0]                   otp_rdata_q,
  output logic                               otp_done_q,
  output logic                               otp_reject_q,
  output logic      [31:0]                   prot_settings_q,
  output logic                               otp_redund_q,
  input  wire logic [2:0]                    boot_strap,
  output logic      [2:0]                    boot_src_q,
  output logic                               boot_otp_q,
  output logic                               cpu_start_q,
  input  wire logic                          sw_req,
  output logic                               sw_grant_q,
  output logic                               sw_deny_q,
  input  wire logic                          sram_req,
  input  wire logic                          sram_we,
  input  wire logic [3:0]                    sram_be,
  input  wire logic [tos_pkg::TOS_SRAM_AW-1:0] sram_addr,
  input  wire logic [31:0]                   sram_wdata,
  output logic      [31:0]                   sram_rdata_q,
  output logic                               sram_rvalid_q,
  input  wire logic                          tck,
  input  wire logic                          trst_n,
  input  wire logic                          tms,
  input  wire logic                          tdi,
  output logic                               tdo_q,
  output logic                               tdo_oe_q,
  output logic                               chip_sel_q,
  output logic                               chip_tms_q,
  output logic                               chip_tdi_q,
  input  wire logic                          chip_tdo
);
  import tos_pkg::*;

  // ==========================================================
  // otp array and protection row (fuses: no reset, blank is zero)
  logic [31:0] otp_mem [TOS_OTP_WORDS] = '{default: 32'h0000_0000};
  logic [31:0] otp_prot_q = 32'h0000_0000;
  logic [31:0] settings_q;
  tos_boot_e   boot_q;
  logic [TOS_OTP_AW-1:0] copy_idx_q;
  logic        ctl_prev_q;
  logic        rd_prev_q;
  logic        prog_ev;
  logic        rd_ev;
  logic [1:0]  sect;
  logic        sect_lock;
  logic        prog_ok;
  logic        done_q;

  assign prog_ev   = otp_ctrl_port[TOS_CTL_PROG] & ~ctl_prev_q;
  assign rd_ev     = otp_ctrl_port[TOS_CTL_READ] & ~rd_prev_q;
  assign sect      = otp_addr_port[TOS_OTP_AW-1:TOS_ROW_AW];
  assign sect_lock = settings_q[TOS_BIT_LOCK_LO + 32'(sect)];
  // master lock beats everything, sector locks only guard array rows
  assign prog_ok   = ~settings_q[TOS_BIT_MASTER] &
                     (otp_ctrl_port[TOS_CTL_PROT] | ~sect_lock);

  // strobe edge memories so a held control bit programs once
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      ctl_prev_q <= 1'b0;
      rd_prev_q  <= 1'b0;
    end else begin
      ctl_prev_q <= otp_ctrl_port[TOS_CTL_PROG];
      rd_prev_q  <= otp_ctrl_port[TOS_CTL_READ];
    end
  end

  // fuse programming only ever blows bits, so it is an or
  always_ff @(posedge clk) begin
    if (rst_n && prog_ev && prog_ok) begin
      if (otp_ctrl_port[TOS_CTL_PROT]) begin
        otp_prot_q <= otp_prot_q | otp_data_port;
      end else begin
        otp_mem[otp_addr_port[TOS_OTP_AW-1:0]] <= otp_mem[otp_addr_port[TOS_OTP_AW-1:0]] | otp_data_port;
      end
    end
  end

  // programming status and software readback
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      otp_done_q   <= 1'b0;
      otp_reject_q <= 1'b0;
      otp_rdata_q  <= 32'h0000_0000;
    end else begin
      otp_done_q   <= prog_ev & prog_ok;
      otp_reject_q <= prog_ev & ~prog_ok;
      if (rd_ev) begin
        otp_rdata_q <= otp_ctrl_port[TOS_CTL_PROT] ? otp_prot_q : otp_mem[otp_addr_port[TOS_OTP_AW-1:0]];
      end
    end
  end

  // ==========================================================
  // strap synchroniser: change counts when stages two and three agree
  logic [2:0] strap_s1_q, strap_s2_q, strap_s3_q, strap_q;
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      strap_s1_q <= 3'h0;
      strap_s2_q <= 3'h0;
      strap_s3_q <= 3'h0;
      strap_q    <= 3'h0;
    end else begin
      strap_s1_q <= boot_strap;
      strap_s2_q <= strap_s1_q;
      strap_s3_q <= strap_s2_q;
      if (strap_s2_q == strap_s3_q) begin
        strap_q <= strap_s3_q;
      end
    end
  end

  // ==========================================================
  // boot sequencer: load word, copy otp into sram, then start
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      boot_q     <= TOS_BS_LOAD;
      copy_idx_q <= '0;
      done_q     <= 1'b0;
    end else begin
      unique case (boot_q)
        TOS_BS_LOAD: begin
          boot_q <= TOS_BS_COPY;
        end
        TOS_BS_COPY: begin
          copy_idx_q <= copy_idx_q + 11'h001;
          if (copy_idx_q == TOS_OTP_LAST) begin
            boot_q <= TOS_BS_RUN;
            done_q <= 1'b1;
          end
        end
        TOS_BS_RUN: begin
          boot_q <= TOS_BS_RUN;
        end
        default: begin
          boot_q <= TOS_BS_LOAD;
        end
      endcase
    end
  end

  // protection word: taken from otp at boot, then only gains bits
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      settings_q <= TOS_SETTINGS_RST;
    end else if (boot_q == TOS_BS_LOAD) begin
      settings_q <= otp_prot_q;
    end else if (prog_ev && prog_ok && otp_ctrl_port[TOS_CTL_PROT]) begin
      settings_q <= settings_q | otp_data_port;
    end
  end

  // boot outputs and word presented to software, incl. general field
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      prot_settings_q <= TOS_SETTINGS_RST;
      otp_redund_q    <= 1'b0;
      boot_otp_q      <= 1'b0;
      boot_src_q      <= 3'h0;
      cpu_start_q     <= 1'b0;
    end else begin
      prot_settings_q <= settings_q;
      otp_redund_q    <= settings_q[TOS_BIT_REDUND];
      cpu_start_q     <= (boot_q == TOS_BS_COPY) && (copy_idx_q == TOS_OTP_LAST);
      if (boot_q == TOS_BS_COPY && copy_idx_q == TOS_OTP_LAST) begin
        boot_otp_q <= settings_q[TOS_BIT_SEC_BOOT];
        boot_src_q <= settings_q[TOS_BIT_SEC_BOOT] ? 3'h0 : strap_q;
      end
    end
  end

  // switch requests from other tiles
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      sw_grant_q <= 1'b0;
      sw_deny_q  <= 1'b0;
    end else begin
      sw_grant_q <= sw_req & done_q & ~settings_q[TOS_BIT_LINK_OFF];
      sw_deny_q  <= sw_req & (~done_q | settings_q[TOS_BIT_LINK_OFF]);
    end
  end

  // ==========================================================
  // sram bank: copy owns the port until the tile runs
  logic [31:0] sram_mem [TOS_SRAM_WORDS];
  logic        cpu_ok;
  assign cpu_ok = sram_req & done_q;

  // one process owns the whole array, so lanes are picked inside it
  always_ff @(posedge clk) begin
    if (boot_q == TOS_BS_COPY) begin
      sram_mem[32'(copy_idx_q)] <= otp_mem[copy_idx_q];
    end else if (cpu_ok && sram_we) begin
      for (int b = 0; b < 4; b++) begin
        if (sram_be[b]) begin
          sram_mem[sram_addr][8*b +: 8] <= sram_wdata[8*b +: 8];
        end
      end
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      sram_rdata_q  <= 32'h0000_0000;
      sram_rvalid_q <= 1'b0;
    end else begin
      sram_rvalid_q <= cpu_ok & ~sram_we;
      if (cpu_ok && !sram_we) begin
        sram_rdata_q <= sram_mem[sram_addr];
      end
    end
  end

  // ==========================================================
  // test port otp read service, toggle handshake from tck
  logic       jreq_s1_q, jreq_s2_q, jreq_s3_q;
  logic       jack_q;
  logic [31:0] jdata_q;
  logic [TOS_OTP_AW-1:0] jaddr_q;
  logic       jreq_q;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      jreq_s1_q <= 1'b0;
      jreq_s2_q <= 1'b0;
      jreq_s3_q <= 1'b0;
      jack_q    <= 1'b0;
      jdata_q   <= 32'h0000_0000;
    end else begin
      jreq_s1_q <= jreq_q;
      jreq_s2_q <= jreq_s1_q;
      jreq_s3_q <= jreq_s2_q;
      if (jreq_s2_q != jreq_s3_q) begin
        jdata_q <= otp_mem[jaddr_q];
        jack_q  <= ~jack_q;
      end
    end
  end

  // ==========================================================
  // tck domain: settings keep following settings_q, which still gains bits after done is seen there
  logic     done_t1_q, done_t2_q, done_t3_q, done_t_q;
  logic     ack_t1_q, ack_t2_q;
  logic [31:0] set_t1_q, set_t2_q, set_t3_q, set_t_q;
  logic     jtag_blk, otp_blk;
  tos_tap_e tap_q, tap_d;
  logic [TOS_IR_LEN-1:0] ir_q, ir_sh_q;
  logic [TOS_DR_LEN-1:0] dr_sh_q;
  logic [31:0] test_port_identification, usercode;

  assign jtag_blk = ~done_t_q | set_t_q[TOS_BIT_JTAG_OFF];
  assign otp_blk  = ~done_t_q | set_t_q[TOS_BIT_JOTP_OFF];
  assign test_port_identification   = {ID_VERSION, ID_PART, ID_MAKER, 1'b1};
  assign usercode = {set_t_q[TOS_UID_HI:TOS_UID_LO], TOS_UC_UNUSED, SI_REVISION};

  always_ff @(posedge tck or negedge trst_n) begin
    if (!trst_n) begin
      done_t1_q <= 1'b0;
      done_t2_q <= 1'b0;
      done_t3_q <= 1'b0;
      done_t_q  <= 1'b0;
      ack_t1_q  <= 1'b0;
      ack_t2_q  <= 1'b0;
      set_t1_q  <= TOS_SETTINGS_RST;
      set_t2_q  <= TOS_SETTINGS_RST;
      set_t3_q  <= TOS_SETTINGS_RST;
      set_t_q   <= TOS_SETTINGS_RST;
    end else begin
      done_t1_q <= done_q;
      done_t2_q <= done_t1_q;
      done_t3_q <= done_t2_q;
      if (done_t2_q == done_t3_q) begin
        done_t_q <= done_t3_q;
      end
      ack_t1_q  <= jack_q;
      ack_t2_q  <= ack_t1_q;
      // word only gains bits and rarely moves: take it once two samples agree
      set_t1_q  <= settings_q;
      set_t2_q  <= set_t1_q;
      set_t3_q  <= set_t2_q;
      if (set_t2_q == set_t3_q) begin
        set_t_q <= set_t3_q;
      end
    end
  end

  // tap state walk
  always_comb begin
    unique case (tap_q)
      TOS_TLR: tap_d = tms ? TOS_TLR : TOS_RTI;
      TOS_RTI: tap_d = tms ? TOS_SDS : TOS_RTI;
      TOS_SDS: tap_d = tms ? TOS_SIS : TOS_CDR;
      TOS_CDR: tap_d = tms ? TOS_E1D : TOS_SDR;
      TOS_SDR: tap_d = tms ? TOS_E1D : TOS_SDR;
      TOS_E1D: tap_d = tms ? TOS_UDR : TOS_PDR;
      TOS_PDR: tap_d = tms ? TOS_E2D : TOS_PDR;
      TOS_E2D: tap_d = tms ? TOS_UDR : TOS_SDR;
      TOS_UDR: tap_d = tms ? TOS_SDS : TOS_RTI;
      TOS_SIS: tap_d = tms ? TOS_TLR : TOS_CIR;
      TOS_CIR: tap_d = tms ? TOS_E1I : TOS_SIR;
      TOS_SIR: tap_d = tms ? TOS_E1I : TOS_SIR;
      TOS_E1I: tap_d = tms ? TOS_UIR : TOS_PIR;
      TOS_PIR: tap_d = tms ? TOS_E2I : TOS_PIR;
      TOS_E2I: tap_d = tms ? TOS_UIR : TOS_SIR;
      TOS_UIR: tap_d = tms ? TOS_SDS : TOS_RTI;
      default: tap_d = TOS_TLR;
    endcase
  end

  // tap registers; otp address stays put until the answer returns
  always_ff @(posedge tck or negedge trst_n) begin
    if (!trst_n) begin
      tap_q   <= TOS_TLR;
      ir_q    <= TOS_IR_TEST_PORT_IDENTIFICATION;
      ir_sh_q <= '0;
      dr_sh_q <= '0;
      jreq_q  <= 1'b0;
      jaddr_q <= '0;
    end else begin
      tap_q <= tap_d;
      if (tap_q == TOS_TLR) begin
        ir_q <= TOS_IR_TEST_PORT_IDENTIFICATION;
      end
      if (tap_q == TOS_CIR) begin
        ir_sh_q <= TOS_IR_CAPTURE;
      end else if (tap_q == TOS_SIR) begin
        ir_sh_q <= {tdi, ir_sh_q[TOS_IR_LEN-1:1]};
      end else if (tap_q == TOS_UIR) begin
        ir_q <= ir_sh_q;
      end
      if (tap_q == TOS_CDR) begin
        unique case (ir_q)
          TOS_IR_TEST_PORT_IDENTIFICATION:   dr_sh_q <= test_port_identification;
          TOS_IR_USERCODE: dr_sh_q <= usercode;
          TOS_IR_OTP_RD:   dr_sh_q <= (otp_blk || ack_t2_q != jreq_q) ? 32'h0000_0000 : jdata_q;
          default:         dr_sh_q <= 32'h0000_0000;
        endcase
      end else if (tap_q == TOS_SDR) begin
        dr_sh_q <= {tdi, dr_sh_q[TOS_DR_LEN-1:1]};
      end else if (tap_q == TOS_UDR && ir_q == TOS_IR_OTP_RD && !otp_blk && ack_t2_q == jreq_q) begin
        jaddr_q <= dr_sh_q[TOS_OTP_AW-1:0];
        jreq_q  <= ~jreq_q;
      end
    end
  end

  // chip tap path, closed while tile access is blocked
  always_ff @(posedge tck or negedge trst_n) begin
    if (!trst_n) begin
      chip_sel_q <= 1'b0;
      chip_tms_q <= 1'b1;
      chip_tdi_q <= 1'b0;
    end else begin
      chip_sel_q <= (ir_q == TOS_IR_CHIP) && !jtag_blk;
      chip_tms_q <= ((ir_q == TOS_IR_CHIP) && !jtag_blk) ? tms : 1'b1;
      chip_tdi_q <= tdi;
    end
  end

  // tdo changes on the falling edge as the standard port expects
  always_ff @(negedge tck or negedge trst_n) begin
    if (!trst_n) begin
      tdo_q    <= 1'b0;
      tdo_oe_q <= 1'b0;
    end else begin
      tdo_oe_q <= (tap_q == TOS_SIR) || (tap_q == TOS_SDR);
      if (tap_q == TOS_SIR) begin
        tdo_q <= ir_sh_q[0];
      end else if (ir_q == TOS_IR_CHIP) begin
        tdo_q <= chip_sel_q ? chip_tdo : 1'b0;
      end else begin
        tdo_q <= dr_sh_q[0];
      end
    end
  end

  // ==========================================================
  // checks
  sequence s_capture_id;
    tap_q == TOS_CDR && ir_q == TOS_IR_TEST_PORT_IDENTIFICATION;
  endsequence
  sequence s_copy_end;
    boot_q == TOS_BS_COPY && copy_idx_q == TOS_OTP_LAST;
  endsequence

  link_refuse_a: assert property (@(posedge clk) disable iff (!rst_n)
    sw_req && settings_q[TOS_BIT_LINK_OFF] |=> sw_deny_q && !sw_grant_q) else $error("switch request not refused");
  master_lock_a: assert property (@(posedge clk) disable iff (!rst_n)
    prog_ev && settings_q[TOS_BIT_MASTER] |=> otp_reject_q && $stable(otp_prot_q)) else $error("master lock ignored");
  sector_lock_a: assert property (@(posedge clk) disable iff (!rst_n)
    prog_ev && !otp_ctrl_port[TOS_CTL_PROT] && sect_lock |=> otp_reject_q && !otp_done_q) else $error("sector lock ignored");
  prot_sticky_a: assert property (@(posedge clk) disable iff (!rst_n)
    (($past(otp_prot_q) & ~otp_prot_q) == 32'h0000_0000)) else $error("programmed bit cleared");
  word_load_a: assert property (@(posedge clk) disable iff (!rst_n)
    rst_n && boot_q == TOS_BS_LOAD |=> settings_q == $past(otp_prot_q) && boot_q == TOS_BS_COPY)
    else $error("word not loaded");
  start_after_a: assert property (@(posedge clk) disable iff (!rst_n)
    s_copy_end |=> cpu_start_q && boot_otp_q == $past(settings_q[TOS_BIT_SEC_BOOT]) ##1 !cpu_start_q)
    else $error("start not after copy");
  sram_cycle_a: assert property (@(posedge clk) disable iff (!rst_n)
    sram_req && done_q && !sram_we |=> sram_rvalid_q && sram_rdata_q == $past(sram_mem[sram_addr]))
    else $error("sram read late");
  test_port_identification_lsb_a: assert property (@(posedge tck) disable iff (!trst_n)
    s_capture_id |=> dr_sh_q[0] && dr_sh_q == test_port_identification) else $error("test_port_identification capture wrong");
  chip_block_a: assert property (@(posedge tck) disable iff (!trst_n)
    jtag_blk |=> !chip_sel_q && chip_tms_q) else $error("chip path open while blocked");
  otp_deny_a: assert property (@(posedge tck) disable iff (!trst_n)
    tap_q == TOS_CDR && ir_q == TOS_IR_OTP_RD && otp_blk |=> dr_sh_q == 32'h0000_0000 && $stable(jreq_q))
    else $error("otp reached while denied");
endmodule : tos_top

// ---- tb/tos_host.sv ----
// jtag host model driving the test port, with a stand-in chip tap
`timescale 1ns/1ps
module tos_host (
  output logic      tck,
  output logic      trst_n,
  output logic      tms,
  output logic      tdi,
  input  wire logic tdo_q,
  output logic      chip_tdo
);
  // ==========================================
  // power up: test reset low, clock parked low outside frames
  initial begin
    tck = 1'b0;
    trst_n = 1'b0;
    tms = 1'b1;
    tdi = 1'b0;
    chip_tdo = 1'b0;
  end
  // chip tap answer toggles so a stale level never passes for data
  always @(negedge tck) chip_tdo <= ~chip_tdo;
  // one 15 ns tck period; tdo sampled just before the rising edge
  task automatic step(input logic m, input logic d, output logic o);
    tms = m;
    tdi = d;
    #7.5;
    o = tdo_q;
    tck = 1'b1;
    #7.5;
    tck = 1'b0;
  endtask : step
  // reset held low across one edge, then park in run-test/idle
  task automatic tap_reset;
    logic o;
    trst_n = 1'b0;
    step(1'b1, 1'b0, o);
    trst_n = 1'b1;
    step(1'b0, 1'b0, o);
  endtask : tap_reset
  // idle -> shift ir or dr, lsb first -> update -> idle
  task automatic scan(input logic ir, input logic [31:0] din, input int n, output logic [31:0] dout);
    logic o;
    dout = 32'h0000_0000;
    step(1'b1, 1'b0, o);
    if (ir) step(1'b1, 1'b0, o);
    step(1'b0, 1'b0, o);
    step(1'b0, 1'b0, o);
    for (int i = 0; i < n; i++) begin
      step(i == n - 1, din[i], o);
      dout[i] = o;
    end
    step(1'b1, 1'b0, o);
    step(1'b0, 1'b0, o);
  endtask : scan
endmodule : tos_host

// ---- tb/tos_top_bench.sv ----
// self-checking bench for the tile otp security block
`timescale 1ns/1ps
module tos_top_bench;
  import tos_pkg::*;
  localparam logic [3:0]  VER = 4'h3;     // arbitrary value
  localparam logic [15:0] PART = 16'hA5C3; // arbitrary value
  localparam logic [10:0] MAKER = 11'h2B6; // arbitrary value
  localparam logic [15:0] REV = 16'h0019;  // arbitrary value
  logic        clk = 1'b0, rst_n = 1'b0, sw_req = 1'b0, sram_req = 1'b0, sram_we = 1'b0;
  logic [15:0] otp_addr_port = 16'h0000, otp_ctrl_port = 16'h0000, oa;
  logic [31:0] otp_data_port = 32'h0000_0000, sram_wdata = 32'h0000_0000, q, w1, w2, acc, d0;
  logic [31:0] otp_rdata_q, prot_settings_q, sram_rdata_q;
  logic [14:0] sram_addr = 15'h0000, a;
  logic [3:0]  sram_be = 4'h0, be;
  logic [2:0]  boot_strap = 3'h5, boot_src_q;
  logic [1:0]  r;
  logic        otp_done_q, otp_reject_q, otp_redund_q, boot_otp_q, cpu_start_q, sw_grant_q, sw_deny_q;
  logic        sram_rvalid_q, tck, trst_n, tms, tdi, tdo_q, tdo_oe_q, chip_sel_q, chip_tms_q;
  logic        chip_tdi_q, chip_tdo;
  int          seed = 25, fail_count = 0, total_checks = 0, lat;
  tos_top #(.ID_VERSION(VER), .ID_PART(PART), .ID_MAKER(MAKER), .SI_REVISION(REV)) i_dut (
    .clk, .rst_n, .otp_addr_port, .otp_data_port, .otp_ctrl_port, .otp_rdata_q, .otp_done_q,
    .otp_reject_q, .prot_settings_q, .otp_redund_q, .boot_strap, .boot_src_q, .boot_otp_q,
    .cpu_start_q, .sw_req, .sw_grant_q, .sw_deny_q, .sram_req, .sram_we, .sram_be, .sram_addr,
    .sram_wdata, .sram_rdata_q, .sram_rvalid_q, .tck, .trst_n, .tms, .tdi, .tdo_q, .tdo_oe_q,
    .chip_sel_q, .chip_tms_q, .chip_tdi_q, .chip_tdo);
  tos_host i_host (.tck, .trst_n, .tms, .tdi, .tdo_q, .chip_tdo);
  // ==========================================
  // 40 MHz tile clock
  always #12.5 clk = ~clk;
  // verdict in one place
  task automatic close_out;
    $display("checks %0d mismatches %0d", total_checks, fail_count);
    if (fail_count == 0 && total_checks > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask : close_out
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      fail_count++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check
  // byte-lane merge expected from a partial store
  function automatic logic [31:0] merge(input logic [31:0] o, input logic [31:0] n, input logic [3:0] b);
    for (int k = 0; k < 4; k++) begin
      if (b[k]) o[8*k +: 8] = n[8*k +: 8];
    end
    return o;
  endfunction : merge
  // ==========================================
  // reset held 3 cycles, then bounded wait for the boot copy
  task automatic boot;
    int n;
    n = 0;
    rst_n <= 1'b0;
    repeat (3) @(posedge clk);
    rst_n <= 1'b1;
    while (cpu_start_q !== 1'b1 && n < 3000) begin
      @(posedge clk);
      #1;
      n++;
    end
    if (n == 3000) begin
      fail_count++;
      close_out();
    end
  endtask : boot
  // program one word; ctrl held until the answer, result {done, reject}
  task automatic prog(input logic [15:0] ad, input logic [31:0] d, input logic p, output logic [1:0] res);
    @(posedge clk);
    otp_addr_port <= ad;
    otp_data_port <= d;
    otp_ctrl_port <= {14'h0000, p, 1'b1};
    res = 2'b00;
    for (int i = 0; i < 4 && res === 2'b00; i++) begin
      @(posedge clk);
      #1;
      res = {otp_done_q, otp_reject_q};
    end
    @(posedge clk);
    otp_ctrl_port <= 16'h0000;
    @(posedge clk);
    if (res === 2'b00) begin
      fail_count++;
      close_out();
    end
  endtask : prog
  task automatic rd(input logic [15:0] ad, input logic p, output logic [31:0] d);
    @(posedge clk);
    otp_addr_port <= ad;
    otp_ctrl_port <= {13'h0000, 1'b1, p, 1'b0};
    repeat (2) @(posedge clk);
    otp_ctrl_port <= 16'h0000;
    @(posedge clk);
    #1;
    d = otp_rdata_q;
  endtask : rd
  // one cpu access; a read polls rvalid and counts the wait
  task automatic mem(input logic we, input logic [14:0] ad, input logic [3:0] b, input logic [31:0] d);
    @(posedge clk);
    {sram_req, sram_we, sram_addr, sram_be, sram_wdata} <= {1'b1, we, ad, b, d};
    lat = 0;
    @(posedge clk);
    sram_req <= 1'b0;
    #1;
    while (!we && sram_rvalid_q !== 1'b1 && lat < 3) begin
      @(posedge clk);
      #1;
      lat++;
    end
    q = sram_rdata_q;
  endtask : mem
  task automatic sw(output logic [1:0] res);
    @(posedge clk);
    sw_req <= 1'b1;
    @(posedge clk);
    sw_req <= 1'b0;
    #1;
    res = {sw_grant_q, sw_deny_q};
    @(posedge clk);
    #1;
    res = res | {sw_grant_q, sw_deny_q};
  endtask : sw
  // ==========================================
  // main sequence
  initial begin
    boot();
    check(boot_otp_q, 1'b0);
    check(boot_src_q, 3'h5);
    i_host.tap_reset();
    i_host.scan(1'b1, 32'h1, 4, q);
    check(q[3:0], 4'h1);
    i_host.scan(1'b0, 32'h0, 32, q);
    check(q, {VER, PART, MAKER, 1'b1});
    i_host.scan(1'b1, 32'h8, 4, q);
    i_host.scan(1'b0, 32'h0, 32, q);
    check(q, {10'h000, 6'h00, REV});
    $display("test identification done");
    for (int i = 0; i < 4; i++) begin
      w1 = $random(seed);
      oa = {5'h00, 2'(i % 3 + 1), 9'h1FF - 9'(i)};
      if (i == 0) {d0, a} = {w1, oa[14:0]};
      prog(oa, w1, 1'b0, r);
      check(r, 2'b10);
      rd(oa, 1'b0, q);
      check(q, w1);
      w2 = $random(seed);
      be = $random(seed);
      mem(1'b1, 15'h0800 + 15'(i), 4'hF, w1);
      mem(1'b1, 15'h0800 + 15'(i), be, w2);
      mem(1'b0, 15'h0800 + 15'(i), 4'h0, 32'h0);
      check(q, merge(w1, w2, be));
      check(lat, 0);
    end
    sw(r);
    check(r, 2'b10);
    $display("test rows and sram done");
    acc = {10'($random(seed)), 7'($random(seed)), 15'h0082};
    prog(16'h0000, acc, 1'b1, r);
    repeat (2) @(posedge clk);
    #1;
    check(prot_settings_q, acc);
    check(otp_redund_q, 1'b1);
    rd(16'h0000, 1'b1, q);
    check(q, acc);
    sw(r);
    check(r, 2'b01);
    i_host.scan(1'b1, 32'h8, 4, q);
    i_host.scan(1'b0, 32'h0, 32, q);
    check(q, {acc[31:22], 6'h00, REV});
    i_host.scan(1'b1, 32'h3, 4, q);
    i_host.scan(1'b0, 32'(a), 32, q);
    repeat (8) @(posedge clk);
    i_host.scan(1'b0, 32'(a), 32, q);
    check(q, d0);
    i_host.scan(1'b1, 32'h2, 4, q);
    i_host.step(1'b0, 1'b1, r[0]);
    check({chip_sel_q, chip_tms_q, chip_tdi_q, tdo_oe_q}, 4'hA);
    for (int s = 0; s < 4; s++) begin
      acc = acc | (32'h100 << s);
      prog(16'h0000, 32'h100 << s, 1'b1, r);
      prog({5'h00, 2'(s), 9'h000}, 32'hFFFF_FFFF, 1'b0, r);
      check(r, 2'b01);
      rd({5'h00, 2'(s), 9'h000}, 1'b0, q);
      check(q, 32'h0);
    end
    prog(16'h0000, 32'h0, 1'b1, r);
    rd(16'h0000, 1'b1, q);
    check(q, acc);
    acc = acc | 32'h3021;
    prog(16'h0000, 32'h3021, 1'b1, r);
    prog(16'h0000, 32'h4000, 1'b1, r);
    check(r, 2'b01);
    i_host.scan(1'b1, 32'h2, 4, q);
    i_host.step(1'b0, 1'b1, r[0]);
    check({chip_sel_q, chip_tms_q}, 2'b01);
    i_host.scan(1'b1, 32'h3, 4, q);
    i_host.scan(1'b0, 32'(a), 32, q);
    repeat (8) @(posedge clk);
    i_host.scan(1'b0, 32'(a), 32, q);
    check(q, 32'h0);
    $display("test locks done");
    boot();
    check(prot_settings_q, acc);
    check({boot_otp_q, boot_src_q}, 4'h8);
    mem(1'b0, a, 4'h0, 32'h0);
    check(q, d0);
    $display("test secure boot done");
    close_out();
  end
endmodule : tos_top_bench
